/* design/sbg_pkg.sv */
// ----------------------------------------------------------------
// Serial baud generator constants
// ----------------------------------------------------------------
package sbg_pkg;

    // Bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int REG_W = 8;
    localparam int DIV_W = 16;
    localparam int PRESC_W = 6;

    // Byte offsets of the four registers
    localparam logic [ADDR_W-1:0] OFS_BAUD_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_STATUS_CONTROL = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_DIVISOR_LOW = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_DIVISOR_HIGH = 5'h0C;

    // Baud control bit positions
    localparam int BC_AUTOBAUD_OVF = 7;
    localparam int BC_RX_IDLE = 6;
    localparam int BC_POLARITY = 4;
    localparam int BC_WIDE_SEL = 3;
    localparam int BC_WAKEUP_EN = 1;
    localparam int BC_AUTOBAUD_EN = 0;

    // Transmit status/control bit positions
    localparam int TS_CLOCK_SRC = 7;
    localparam int TS_NINE_BIT = 6;
    localparam int TS_TX_ENABLE = 5;
    localparam int TS_SYNC_MODE = 4;
    localparam int TS_BREAK_SEND = 3;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_SHIFT_EMPTY = 1;
    localparam int TS_NINTH_BIT = 0;

    // Writable masks and reset values
    localparam logic [REG_W-1:0] BC_WR_MASK = 8'h1B;
    localparam logic [REG_W-1:0] TS_WR_MASK = 8'hFD;
    localparam logic [REG_W-1:0] BC_RESET = 8'h00;
    localparam logic [REG_W-1:0] TS_RESET = 8'h00;
    localparam logic [REG_W-1:0] DIV_RESET = 8'h00;

    // Prescale terminal counts: divide by 64, 16 and 4
    localparam logic [PRESC_W-1:0] PRESC_LAST_SLOW = 6'h3F;
    localparam logic [PRESC_W-1:0] PRESC_LAST_MID = 6'h0F;
    localparam logic [PRESC_W-1:0] PRESC_LAST_FAST = 6'h03;

endpackage

/* design/sbg_timer.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Free-running baud timer with prescaler
// ----------------------------------------------------------------
module sbg_timer import sbg_pkg::*; (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic clearTimer,
    input wire logic wideSel,
    input wire logic highSpeed,
    input wire logic syncMode,
    input wire logic [DIV_W-1:0] divisor,
    output logic baudTick_q
);
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] prescLast;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] divEff;
    logic prescWrap;
    logic cntWrap;

    // Divide factor select; high speed bit ignored when synchronous
    always_comb begin
        if (syncMode) begin
            prescLast = PRESC_LAST_FAST;
        end else begin
            unique case ({highSpeed, wideSel})
                2'b00: prescLast = PRESC_LAST_SLOW;
                2'b11: prescLast = PRESC_LAST_FAST;
                default: prescLast = PRESC_LAST_MID;
            endcase
        end
    end

    // Narrow mode uses only the low divisor byte
    assign divEff = wideSel ? divisor : {8'h00, divisor[7:0]};
    assign prescWrap = (presc_q >= prescLast);
    assign cntWrap = prescWrap && (cnt_q >= divEff);

    // Prescaler; >= keeps it safe when the factor shrinks mid-count
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            presc_q <= '0;
        end else if (clkEn) begin
            if (clearTimer || prescWrap) begin
                presc_q <= '0;
            end else begin
                presc_q <= presc_q + 6'h01;
            end
        end
    end

    // Divisor counter, reloads after each tick
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (clkEn) begin
            if (clearTimer || cntWrap) begin
                cnt_q <= '0;
            end else if (prescWrap) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // One-cycle tick at each full period
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            baudTick_q <= 1'b0;
        end else if (clkEn) begin
            baudTick_q <= cntWrap && !clearTimer;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    clear_restarts_count_a: assert property (clkEn && clearTimer |=> cnt_q == 16'h0000 && presc_q == 6'h00)
        else $error("timer not cleared by divisor write");
    tick_needs_wrap_a: assert property (clkEn && !cntWrap |=> !baudTick_q)
        else $error("tick without terminal count");
    narrow_ignores_high_a: assert property (!wideSel |-> divEff[15:8] == 8'h00)
        else $error("high divisor byte used in narrow mode");
    sync_fast_factor_a: assert property (syncMode |-> prescLast == PRESC_LAST_FAST)
        else $error("sync mode factor not four");
endmodule

/* design/sbg_top.sv */
`timescale 1ns/1ps
module sbg_top import sbg_pkg::*; (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Status from the shift logic
    input wire logic receiveIdleIn,
    input wire logic shiftEmptyIn,
    input wire logic autobaudOverflowIn,
    input wire logic breakDoneIn,
    // Controls to the shift logic
    output logic baudTick,
    output logic clockDataPolarity,
    output logic wakeupEnable,
    output logic autobaudEnable,
    output logic clockSourceSelect,
    output logic nineBitTransmit,
    output logic transmitEnable,
    output logic syncMode,
    output logic breakSend,
    output logic ninthTransmitBit
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [REG_W-1:0] baudControl_q;
    logic [REG_W-1:0] txStatusControl_q;
    logic [REG_W-1:0] divisorLow_q;
    logic [REG_W-1:0] divisorHigh_q;
    logic receiveIdle_q;
    logic shiftEmpty_q;
    logic autobaudOvf_q;
    logic waitReq_q;
    logic [DATA_W-1:0] readData_q;
    logic divWrite_q;
    logic baudTickInt;

    // Bus decode
    logic busReq;
    logic busAccept;
    logic wrAccept;
    logic lowLane;
    logic hitBaud;
    logic hitTx;
    logic hitDivLow;
    logic hitDivHigh;
    logic [REG_W-1:0] readSel;

    assign busReq = avs_read || avs_write;
    assign busAccept = busReq && !waitReq_q;
    assign wrAccept = avs_write && !waitReq_q && lowLane;
    assign lowLane = avs_byteenable[0];
    assign hitBaud = (avs_address == OFS_BAUD_CONTROL);
    assign hitTx = (avs_address == OFS_TX_STATUS_CONTROL);
    assign hitDivLow = (avs_address == OFS_DIVISOR_LOW);
    assign hitDivHigh = (avs_address == OFS_DIVISOR_HIGH);

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------

    // Waitrequest drops for one cycle, one edge after a request appears
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            waitReq_q <= 1'b1;
        end else if (clkEn) begin
            if (!waitReq_q) begin
                waitReq_q <= 1'b1;
            end else if (busReq) begin
                waitReq_q <= 1'b0;
            end
        end
    end

    // Read word assembly; unused bits and unmapped offsets give zero
    always_comb begin
        readSel = 8'h00;
        if (hitBaud) begin
            readSel = baudControl_q;
            readSel[BC_AUTOBAUD_OVF] = autobaudOvf_q;
            readSel[BC_RX_IDLE] = receiveIdle_q;
        end else if (hitTx) begin
            readSel = txStatusControl_q;
            readSel[TS_SHIFT_EMPTY] = shiftEmpty_q;
        end else if (hitDivLow) begin
            readSel = divisorLow_q;
        end else if (hitDivHigh) begin
            readSel = divisorHigh_q;
        end
    end

    // Read data is loaded as waitrequest falls and held until the next read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            readData_q <= '0;
        end else if (clkEn) begin
            if (avs_read && waitReq_q) begin
                readData_q <= {24'h000000, readSel};
            end
        end
    end

    assign avs_readdata = readData_q;
    assign avs_waitrequest = waitReq_q;

    // ----------------------------------------------------------------
    // Status sampling
    // ----------------------------------------------------------------

    // Shift logic flags are registered before software sees them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            receiveIdle_q <= 1'b1;
            shiftEmpty_q <= 1'b1;
            autobaudOvf_q <= 1'b0;
        end else if (clkEn) begin
            receiveIdle_q <= receiveIdleIn;
            shiftEmpty_q <= shiftEmptyIn;
            autobaudOvf_q <= autobaudOverflowIn;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------

    // Baud control; read-only and unused bits never store
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            baudControl_q <= BC_RESET;
        end else if (clkEn) begin
            if (wrAccept && hitBaud) begin
                baudControl_q <= avs_writedata[7:0] & BC_WR_MASK;
            end
        end
    end

    // Transmit control; break request self-clears, a software write wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txStatusControl_q <= TS_RESET;
        end else if (clkEn) begin
            if (wrAccept && hitTx) begin
                txStatusControl_q <= avs_writedata[7:0] & TS_WR_MASK;
            end else if (breakDoneIn) begin
                txStatusControl_q[TS_BREAK_SEND] <= 1'b0;
            end
        end
    end

    // Divisor bytes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divisorLow_q <= DIV_RESET;
            divisorHigh_q <= DIV_RESET;
        end else if (clkEn) begin
            if (wrAccept && hitDivLow) begin
                divisorLow_q <= avs_writedata[7:0];
            end
            if (wrAccept && hitDivHigh) begin
                divisorHigh_q <= avs_writedata[7:0];
            end
        end
    end

    // Either divisor write restarts the timer on the next cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divWrite_q <= 1'b0;
        end else if (clkEn) begin
            divWrite_q <= wrAccept && (hitDivLow || hitDivHigh);
        end
    end

    // ----------------------------------------------------------------
    // Baud timer
    // ----------------------------------------------------------------
    sbg_timer u_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .clkEn(clkEn),
        .clearTimer(divWrite_q),
        .wideSel(baudControl_q[BC_WIDE_SEL]),
        .highSpeed(txStatusControl_q[TS_HIGH_SPEED]),
        .syncMode(txStatusControl_q[TS_SYNC_MODE]),
        .divisor({divisorHigh_q, divisorLow_q}),
        .baudTick_q(baudTickInt)
    );

    // Control outputs come straight from register bits
    assign baudTick = baudTickInt;
    assign clockDataPolarity = baudControl_q[BC_POLARITY];
    assign wakeupEnable = baudControl_q[BC_WAKEUP_EN];
    assign autobaudEnable = baudControl_q[BC_AUTOBAUD_EN];
    assign clockSourceSelect = txStatusControl_q[TS_CLOCK_SRC];
    assign nineBitTransmit = txStatusControl_q[TS_NINE_BIT];
    assign transmitEnable = txStatusControl_q[TS_TX_ENABLE];
    assign syncMode = txStatusControl_q[TS_SYNC_MODE];
    assign breakSend = txStatusControl_q[TS_BREAK_SEND];
    assign ninthTransmitBit = txStatusControl_q[TS_NINTH_BIT];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Period helper: cycles since last tick, spoiled by any config change
    logic [23:0] sinceTick_q;
    logic periodValid_q;
    logic [23:0] expectPeriod;
    logic [6:0] factor;

    always_comb begin
        if (syncMode) begin
            factor = 7'h04;
        end else begin
            unique case ({txStatusControl_q[TS_HIGH_SPEED], baudControl_q[BC_WIDE_SEL]})
                2'b00: factor = 7'h40;
                2'b11: factor = 7'h04;
                default: factor = 7'h10;
            endcase
        end
        if (baudControl_q[BC_WIDE_SEL]) begin
            expectPeriod = {17'h00000, factor}
                * ({8'h00, divisorHigh_q, divisorLow_q} + 24'h000001);
        end else begin
            expectPeriod = {17'h00000, factor} * ({16'h0000, divisorLow_q} + 24'h000001);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sinceTick_q <= '0;
            periodValid_q <= 1'b0;
        end else if (!clkEn || wrAccept) begin
            periodValid_q <= 1'b0;
            sinceTick_q <= '0;
        end else if (baudTickInt) begin
            sinceTick_q <= 24'h000001;
            periodValid_q <= 1'b1;
        end else begin
            sinceTick_q <= sinceTick_q + 24'h000001;
        end
    end

    sequence busRequestWait;
        busReq && waitReq_q && clkEn;
    endsequence

    sequence busAnswer;
        !waitReq_q ##1 waitReq_q;
    endsequence

    // Write steps: stored byte lane accepted, or refused for a missing lane
    sequence lowLaneWrite;
        clkEn && avs_write && !waitReq_q && lowLane;
    endsequence

    sequence maskedWrite;
        clkEn && avs_write && !waitReq_q && !lowLane;
    endsequence

    // Hardware break clear with no transmit control write in the same cycle
    sequence breakDoneAlone;
        clkEn && breakDoneIn && !(wrAccept && hitTx);
    endsequence

    // Handshake and timer period
    wait_one_cycle_a: assert property (busRequestWait |=> busAnswer)
        else $error("waitrequest did not pulse low for one cycle");
    tick_period_a: assert property (baudTickInt && periodValid_q && clkEn
        |-> sinceTick_q == expectPeriod)
        else $error("baud period does not match divisor and factor");
    div_write_clears_a: assert property (clkEn && wrAccept && (hitDivLow || hitDivHigh)
        |=> divWrite_q)
        else $error("divisor write did not clear the timer");

    // Read path
    reserved_zero_a: assert property (!waitReq_q |-> avs_readdata[31:8] == 24'h000000
        && (!$past(avs_read && hitBaud)
        || (avs_readdata[5] == 1'b0 && avs_readdata[2] == 1'b0)))
        else $error("reserved read bits not zero");
    empty_flag_read_a: assert property (avs_read && hitTx && waitReq_q && clkEn
        |=> avs_readdata[TS_SHIFT_EMPTY] == $past(shiftEmpty_q))
        else $error("shift empty flag not returned");
    idle_flag_read_a: assert property (avs_read && hitBaud && waitReq_q && clkEn
        |=> avs_readdata[BC_RX_IDLE] == $past(receiveIdle_q))
        else $error("receive idle flag not returned");
    div_low_read_a: assert property (avs_read && hitDivLow && waitReq_q && clkEn
        |=> avs_readdata[7:0] == $past(divisorLow_q))
        else $error("divisor low byte not returned");
    div_high_read_a: assert property (avs_read && hitDivHigh && waitReq_q && clkEn
        |=> avs_readdata[7:0] == $past(divisorHigh_q))
        else $error("divisor high byte not returned");

    // Write path
    div_low_store_a: assert property (lowLaneWrite ##0 hitDivLow
        |=> divisorLow_q == $past(avs_writedata[7:0]))
        else $error("divisor low byte not stored");
    div_high_store_a: assert property (lowLaneWrite ##0 hitDivHigh
        |=> divisorHigh_q == $past(avs_writedata[7:0]))
        else $error("divisor high byte not stored");
    baud_ctrl_store_a: assert property (lowLaneWrite ##0 hitBaud
        |=> baudControl_q == ($past(avs_writedata[7:0]) & BC_WR_MASK))
        else $error("baud control write not stored under mask");
    tx_ctrl_store_a: assert property (lowLaneWrite ##0 hitTx
        |=> txStatusControl_q == ($past(avs_writedata[7:0]) & TS_WR_MASK))
        else $error("transmit control write not stored under mask");
    lane_refused_a: assert property (maskedWrite
        |=> $stable(baudControl_q) && $stable(divisorLow_q) && $stable(divisorHigh_q))
        else $error("write without low byte lane was stored");
    break_self_clear_a: assert property (breakDoneAlone |=> !breakSend)
        else $error("break request not cleared when done");

    // Status, reset and freeze
    status_follow_a: assert property (clkEn |=> receiveIdle_q == $past(receiveIdleIn)
        && autobaudOvf_q == $past(autobaudOverflowIn) && shiftEmpty_q == $past(shiftEmptyIn))
        else $error("status flags do not follow the shift logic");
    freeze_holds_a: assert property (!clkEn |=> $stable(baudTickInt)
        && $stable(waitReq_q) && $stable(divisorLow_q) && $stable(readData_q))
        else $error("state moved while clock enable low");
    reset_narrow_a: assert property ($past(srst) |-> !baudControl_q[BC_WIDE_SEL])
        else $error("timer not narrow after reset");
    sync_output_a: assert property (syncMode == txStatusControl_q[TS_SYNC_MODE]
        && transmitEnable == txStatusControl_q[TS_TX_ENABLE])
        else $error("transmit control outputs disagree with register");
endmodule

/* bench/sbg_shift_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Behavioural shift logic facing the baud generator
// ----------------------------------------------------------------
module sbg_shift_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic baudTick,
    input wire logic breakSend,
    input wire logic rxBusy,
    input wire logic ovfSeen,
    output logic receiveIdleIn,
    output logic shiftEmptyIn,
    output logic autobaudOverflowIn,
    output logic breakDoneIn
);
    int unsigned breakBits = 0;

    // Status levels follow receiver and transmitter activity
    assign receiveIdleIn = !rxBusy;
    assign shiftEmptyIn = !breakSend;
    assign autobaudOverflowIn = ovfSeen;
    assign breakDoneIn = breakSend && (breakBits == 13);

    // A break lasts 13 bit times, counted on baud ticks
    always @(posedge sys_clk) begin
        if (srst || !breakSend) begin
            breakBits <= 0;
        end else if (baudTick && breakBits < 13) begin
            breakBits <= breakBits + 1;
        end
    end
endmodule

/* bench/test_sbg_top.sv */
`timescale 1ns/1ps
module test_sbg_top import sbg_pkg::*;;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic [ADDR_W-1:0] avsAddress = '0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [DATA_W-1:0] avsWritedata = '0;
    logic [BE_W-1:0] avsByteenable = 4'hF;
    logic [DATA_W-1:0] avsReaddata;
    logic avsWaitrequest;
    logic rxBusy = 1'b0;
    logic ovfSeen = 1'b0;
    logic receiveIdleIn, shiftEmptyIn, autobaudOverflowIn, breakDoneIn;
    logic baudTick, clockDataPolarity, wakeupEnable, autobaudEnable, clockSourceSelect;
    logic nineBitTransmit, transmitEnable, syncMode, breakSend, ninthTransmitBit;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    sbg_top sbg_top_i (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .receiveIdleIn(receiveIdleIn), .shiftEmptyIn(shiftEmptyIn),
        .autobaudOverflowIn(autobaudOverflowIn), .breakDoneIn(breakDoneIn),
        .baudTick(baudTick), .clockDataPolarity(clockDataPolarity),
        .wakeupEnable(wakeupEnable), .autobaudEnable(autobaudEnable),
        .clockSourceSelect(clockSourceSelect), .nineBitTransmit(nineBitTransmit),
        .transmitEnable(transmitEnable), .syncMode(syncMode), .breakSend(breakSend),
        .ninthTransmitBit(ninthTransmitBit));

    sbg_shift_model sbg_shift_model_i (.sys_clk(sys_clk), .srst(srst), .baudTick(baudTick),
        .breakSend(breakSend), .rxBusy(rxBusy), .ovfSeen(ovfSeen),
        .receiveIdleIn(receiveIdleIn), .shiftEmptyIn(shiftEmptyIn),
        .autobaudOverflowIn(autobaudOverflowIn), .breakDoneIn(breakDoneIn));

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short after a ceiling well above the expected run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // One Avalon cycle held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                       input logic [BE_W-1:0] be, output logic [31:0] q);
        @(posedge sys_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= {24'h000000, d};
        avsByteenable <= be;
        @(posedge sys_clk);
        while (avsWaitrequest !== 1'b0) @(posedge sys_clk);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hF, q);
        chk(q, exp);
    endtask

    // Counts falling edges until the next tick is seen
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (baudTick !== 1'b1);
    endtask

    // Sets a mode, then measures one full tick period
    task automatic rate(input logic [7:0] ts, input logic [7:0] bc, input logic [7:0] hi,
                        input logic [7:0] lo, input int p);
        int n;
        wr(OFS_TX_STATUS_CONTROL, ts);
        wr(OFS_BAUD_CONTROL, bc);
        wr(OFS_DIVISOR_HIGH, hi);
        wr(OFS_DIVISOR_LOW, lo);
        // A tick launched at the divisor write edge is skipped
        wait_tick(n);
        wait_tick(n);
        wait_tick(n);
        chk(n, p);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(OFS_BAUD_CONTROL, 32'h00000040);
        rd(OFS_TX_STATUS_CONTROL, 32'h00000002);
        rd(OFS_DIVISOR_LOW, 32'h00000000);
        rd(OFS_DIVISOR_HIGH, 32'h00000000);
        rd(5'h10, 32'h00000000);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        wr(OFS_BAUD_CONTROL, 8'hFF);
        rd(OFS_BAUD_CONTROL, 32'h0000005B);
        chk({29'h0, clockDataPolarity, wakeupEnable, autobaudEnable}, 32'h7);
        wr(OFS_TX_STATUS_CONTROL, 8'hF7);
        rd(OFS_TX_STATUS_CONTROL, 32'h000000F7);
        chk({27'h0, clockSourceSelect, nineBitTransmit, transmitEnable, syncMode,
             ninthTransmitBit}, 32'h1F);
        wr(OFS_BAUD_CONTROL, 8'hE4);
        rd(OFS_BAUD_CONTROL, 32'h00000040);
        wr(OFS_TX_STATUS_CONTROL, 8'h00);
        bus(1'b1, OFS_BAUD_CONTROL, 8'h08, 4'h0, q);
        rd(OFS_BAUD_CONTROL, 32'h00000040);
        wr(5'h10, 8'hFF);
        rd(5'h10, 32'h00000000);
    endtask

    task automatic t_status();
        rxBusy <= 1'b1;
        ovfSeen <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(OFS_BAUD_CONTROL, 32'h00000080);
        rxBusy <= 1'b0;
        ovfSeen <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Divisor 0 after reset: 13 ticks of 64 cycles end the break
    task automatic t_break();
        int n;
        wr(OFS_TX_STATUS_CONTROL, 8'h08);
        @(negedge sys_clk);
        chk({31'h0, breakSend}, 32'h1);
        n = 0;
        while (breakSend !== 1'b0) begin
            @(negedge sys_clk);
            n++;
        end
        chk({31'h0, (n >= 760 && n <= 900)}, 32'h1);
    endtask

    // Rewriting the divisor mid-count restarts the full period
    task automatic t_restart();
        int n;
        rate(8'h00, 8'h00, 8'h00, 8'h0F, 1024);
        repeat (300) @(negedge sys_clk);
        wr(OFS_DIVISOR_LOW, 8'h0F);
        wait_tick(n);
        chk({31'h0, (n >= 1021 && n <= 1027)}, 32'h1);
    endtask

    // Software confirms receive idle, then holds the clock still
    task automatic t_freeze();
        int ticks;
        rd(OFS_BAUD_CONTROL, 32'h00000040);
        // Freeze just after a tick so the pulse is not held high
        wait_tick(ticks);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        ticks = 0;
        repeat (100) begin
            @(negedge sys_clk);
            ticks += (baudTick === 1'b1);
        end
        chk(ticks, 0);
        @(posedge sys_clk);
        clkEn <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_break();
        t_regs();
        t_status();
        rate(8'h00, 8'h00, 8'h01, 8'h02, 192);
        rate(8'h04, 8'h00, 8'h00, 8'h02, 48);
        rate(8'h00, 8'h08, 8'h01, 8'h02, 4144);
        rate(8'h04, 8'h08, 8'h01, 8'h02, 1036);
        rate(8'h10, 8'h00, 8'h00, 8'h02, 12);
        rate(8'h14, 8'h00, 8'h00, 8'h02, 12);
        t_freeze();
        rate(8'h10, 8'h08, 8'h01, 8'h02, 1036);
        t_restart();
        end_sim();
    end
endmodule
